// ---- hw/crcs_pkg.sv ----
/*
 * crcs_pkg: constants, state and carrier types of the CRC-16 byte and
 * ROM sector engine.
 * Assumes a 32-bit APB slave port and a byte-wide internal ROM read port.
 */
package crcs_pkg;

    // apb geometry
    localparam int          APB_AW          = 18;
    localparam int          APB_DW          = 32;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_DIN         = 16'h4021;
    localparam logic [15:0] IDX_CTRL        = 16'h4022;
    localparam logic [15:0] IDX_DR          = 16'h4023;
    localparam logic [15:0] IDX_BEG         = 16'h4024;
    localparam logic [15:0] IDX_CNT         = 16'h4025;
    localparam logic [15:0] IDX_IRQ_STS     = 16'h4026;
    localparam logic [15:0] IDX_IRQ_MASK    = 16'h4027;

    // crc_control bit positions
    localparam int          CTRL_PNT        = 0;
    localparam int          CTRL_LAUNCH     = 1;
    localparam int          CTRL_VAL        = 2;
    localparam int          CTRL_INIT       = 3;
    localparam int          CTRL_DONE       = 4;

    // interrupt status / mask bit positions
    localparam int          IRQ_BATCH_DONE  = 0;
    localparam int          IRQ_BYTE_DONE   = 1;
    localparam int          IRQ_W           = 2;

    // crc arithmetic
    localparam logic [15:0] CRC_POLY        = 16'h1021;
    localparam logic [15:0] CRC_INIT_ZERO   = 16'h0000;
    localparam logic [15:0] CRC_INIT_ONES   = 16'hffff;

    // rom geometry: 128 sectors of 256 bytes
    localparam logic [6:0]  SECTOR_LAST     = 7'h7f;
    localparam logic [7:0]  SECTOR_BYTE_LAST = 8'hff;
    localparam logic [7:0]  SECTOR_BYTE_FIRST = 8'h00;

    typedef enum logic [0:0] {
        CRCS_IDLE = 1'b0,
        CRCS_RUN  = 1'b1
    } crcs_fsm_t;

    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [APB_AW-1:0]     paddr;
        logic [APB_DW-1:0]     pwdata;
    } crcs_apb_req_t;

    typedef struct packed {
        crcs_fsm_t             fsm;
        logic [15:0]           crc;
        logic                  pnt;
        logic                  val;
        logic [6:0]            beg;
        logic [6:0]            cnt;
        logic [6:0]            last_sec;
        logic [14:0]           rom_addr;
        logic                  rom_req;
        logic                  pready;
        logic                  pslverr;
        logic [APB_DW-1:0]     prdata;
        logic [IRQ_W-1:0]      irq_sts;
        logic [IRQ_W-1:0]      irq_mask;
        logic                  irq;
    } crcs_state_t;

    // every field of the engine resets to zero (idle, result 0x0000)
    localparam crcs_state_t CRCS_STATE_RST  = '0;

endpackage

// ---- hw/crcs_top.sv ----
/*
 * crcs_top: CRC-16 engine with single-byte feed and ROM sector batch runs,
 * reached over APB.
 * Assumes one clock; the ROM port answers each request with rom_rvalid on
 * the same clock, one answer per request, after any number of cycles.
 */
// Chosen here: the APB slave port.
//
// Contract
// - done flag low during batch, else high; the bus stalls for the whole batch, so done always reads one
// - writing one to init loads result
// - init select: zero or all ones
// - writing one to launch starts batch
// - pointer picks low or high result byte
// - each input byte write updates result
// - input port stores nothing, reads zero
// - result port reads/writes pointed half
// - batch starts at start sector times 256
// - offset field fixes the last sector
// - polynomial x^16+x^12+x^5+1
// - one byte per clock, parallel update
// - every byte of each sector covered
// - range clipped at final sector
`timescale 1ns/1ps
module crcs_top (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [crcs_pkg::APB_AW-1:0]   paddr,
    input  wire logic [crcs_pkg::APB_DW-1:0]   pwdata,
    output logic      [crcs_pkg::APB_DW-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // rom read port
    output logic                               rom_req,
    output logic      [14:0]                   rom_addr,
    input  wire logic [7:0]                    rom_rdata,
    input  wire logic                          rom_rvalid,
    // interrupt
    output logic                               irq
);

    crcs_pkg::crcs_state_t   st_r;
    crcs_pkg::crcs_state_t   st_nxt;
    crcs_pkg::crcs_apb_req_t req;
    logic                    busy;
    logic                    access;
    logic                    commit;
    logic                    sel_din;
    logic                    sel_ctrl;
    logic                    sel_dr;
    logic                    sel_beg;
    logic                    sel_cnt;
    logic                    sel_sts;
    logic                    sel_mask;
    logic                    mapped;
    logic [7:0]              upd_byte;
    logic [15:0]             upd_crc;
    logic [7:0]              sec_sum;
    logic [6:0]              clip_last;
    logic                    last_byte;
    logic [crcs_pkg::APB_DW-1:0] rd_val;

    assign req      = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign busy     = (st_r.fsm == crcs_pkg::CRCS_RUN);
    assign access   = req.psel & req.penable;
    assign commit   = access & st_r.pready;

    assign sel_din  = (req.paddr == {crcs_pkg::IDX_DIN, 2'b00});
    assign sel_ctrl = (req.paddr == {crcs_pkg::IDX_CTRL, 2'b00});
    assign sel_dr   = (req.paddr == {crcs_pkg::IDX_DR, 2'b00});
    assign sel_beg  = (req.paddr == {crcs_pkg::IDX_BEG, 2'b00});
    assign sel_cnt  = (req.paddr == {crcs_pkg::IDX_CNT, 2'b00});
    assign sel_sts  = (req.paddr == {crcs_pkg::IDX_IRQ_STS, 2'b00});
    assign sel_mask = (req.paddr == {crcs_pkg::IDX_IRQ_MASK, 2'b00});
    assign mapped   = sel_din | sel_ctrl | sel_dr | sel_beg | sel_cnt | sel_sts | sel_mask;

    // last sector = start + offset, held at the top sector
    assign sec_sum   = {1'b0, st_r.beg} + {1'b0, st_r.cnt};
    assign clip_last = sec_sum[7] ? crcs_pkg::SECTOR_LAST : sec_sum[6:0];
    assign last_byte = (st_r.rom_addr == {st_r.last_sec, crcs_pkg::SECTOR_BYTE_LAST});

    // one update engine shared by port writes and rom bytes
    assign upd_byte = busy ? rom_rdata : req.pwdata[7:0];

    crcs_update #(
        .POLY    (crcs_pkg::CRC_POLY)
    ) u_update (
        .crc_in  (st_r.crc),
        .data_in (upd_byte),
        .crc_out (upd_crc)
    );

    // read mux; done reads one since the bus stalls for the whole batch
    always_comb begin
        rd_val = '0;
        if (sel_ctrl) begin
            rd_val[crcs_pkg::CTRL_PNT]  = st_r.pnt;
            rd_val[crcs_pkg::CTRL_VAL]  = st_r.val;
            rd_val[crcs_pkg::CTRL_DONE] = ~busy;
        end else if (sel_dr) begin
            rd_val[7:0] = st_r.pnt ? st_r.crc[15:8] : st_r.crc[7:0];
        end else if (sel_beg) begin
            rd_val[6:0] = st_r.beg;
        end else if (sel_cnt) begin
            rd_val[6:0] = st_r.cnt;
        end else if (sel_sts) begin
            rd_val[crcs_pkg::IRQ_W-1:0] = st_r.irq_sts;
        end else if (sel_mask) begin
            rd_val[crcs_pkg::IRQ_W-1:0] = st_r.irq_mask;
        end
        // input port falls through as zero
    end

    always_comb begin
        st_nxt         = st_r;
        st_nxt.rom_req = 1'b0;
        // software is held in wait states for the whole batch
        st_nxt.pready  = access & ~st_r.pready & ~busy;
        st_nxt.pslverr = access & ~st_r.pready & ~busy & ~mapped;
        if (access & ~st_r.pready & ~busy) begin
            st_nxt.prdata = req.pwrite ? '0 : rd_val;
        end

        if (commit & req.pwrite) begin
            if (sel_din) begin
                st_nxt.crc = upd_crc;
            end
            if (sel_ctrl) begin
                st_nxt.pnt = req.pwdata[crcs_pkg::CTRL_PNT];
                st_nxt.val = req.pwdata[crcs_pkg::CTRL_VAL];
                if (req.pwdata[crcs_pkg::CTRL_INIT]) begin
                    st_nxt.crc = req.pwdata[crcs_pkg::CTRL_VAL] ?
                                 crcs_pkg::CRC_INIT_ONES : crcs_pkg::CRC_INIT_ZERO;
                end
                if (req.pwdata[crcs_pkg::CTRL_LAUNCH]) begin
                    st_nxt.fsm      = crcs_pkg::CRCS_RUN;
                    st_nxt.last_sec = clip_last;
                    st_nxt.rom_addr = {st_r.beg, crcs_pkg::SECTOR_BYTE_FIRST};
                    st_nxt.rom_req  = 1'b1;
                end
            end
            if (sel_dr) begin
                if (st_r.pnt) begin
                    st_nxt.crc[15:8] = req.pwdata[7:0];
                end else begin
                    st_nxt.crc[7:0] = req.pwdata[7:0];
                end
            end
            if (sel_beg) begin
                st_nxt.beg = req.pwdata[6:0];
            end
            if (sel_cnt) begin
                st_nxt.cnt = req.pwdata[6:0];
            end
            if (sel_sts) begin
                st_nxt.irq_sts = st_r.irq_sts & ~req.pwdata[crcs_pkg::IRQ_W-1:0];
            end
            if (sel_mask) begin
                st_nxt.irq_mask = req.pwdata[crcs_pkg::IRQ_W-1:0];
            end
        end

        // event sets come after the clear so a coincident event survives
        if (commit & req.pwrite & sel_din) begin
            st_nxt.irq_sts[crcs_pkg::IRQ_BYTE_DONE] = 1'b1;
        end

        unique case (st_r.fsm)
            crcs_pkg::CRCS_IDLE: begin
            end
            crcs_pkg::CRCS_RUN: begin
                if (rom_rvalid) begin
                    st_nxt.crc = upd_crc;
                    if (last_byte) begin
                        st_nxt.fsm = crcs_pkg::CRCS_IDLE;
                        st_nxt.irq_sts[crcs_pkg::IRQ_BATCH_DONE] = 1'b1;
                    end else begin
                        st_nxt.rom_addr = st_r.rom_addr + 15'h0001;
                        st_nxt.rom_req  = 1'b1;
                    end
                end
            end
        endcase

        st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_mask);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= crcs_pkg::CRCS_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata   = st_r.prdata;
    assign pready   = st_r.pready;
    assign pslverr  = st_r.pslverr;
    assign rom_req  = st_r.rom_req;
    assign rom_addr = st_r.rom_addr;
    assign irq      = st_r.irq;

    property p_done_ends_run;
        @(posedge clk) disable iff (!rstn)
        busy && rom_rvalid && last_byte |=> !busy ##0 st_r.irq_sts[crcs_pkg::IRQ_BATCH_DONE];
    endproperty
    a_done_ends_run: assert property (p_done_ends_run) else $error("batch did not end on last byte");

    property p_done_reads_one;
        @(posedge clk) disable iff (!rstn)
        pready && psel && !pwrite && sel_ctrl |-> prdata[crcs_pkg::CTRL_DONE];
    endproperty
    a_done_reads_one: assert property (p_done_reads_one) else $error("done flag read as zero");

    property p_init_value;
        @(posedge clk) disable iff (!rstn)
        commit && pwrite && sel_ctrl && pwdata[crcs_pkg::CTRL_INIT] && !pwdata[crcs_pkg::CTRL_LAUNCH]
        |=> st_r.crc == ($past(pwdata[crcs_pkg::CTRL_VAL]) ? 16'hffff : 16'h0000);
    endproperty
    a_init_value: assert property (p_init_value) else $error("init did not load selected value");

    property p_init_ignored;
        @(posedge clk) disable iff (!rstn)
        commit && pwrite && sel_ctrl && !pwdata[crcs_pkg::CTRL_INIT] && !pwdata[crcs_pkg::CTRL_LAUNCH]
        |=> $stable(st_r.crc);
    endproperty
    a_init_ignored: assert property (p_init_ignored) else $error("zero init bit changed result");

    property p_launch;
        @(posedge clk) disable iff (!rstn)
        commit && pwrite && sel_ctrl && pwdata[crcs_pkg::CTRL_LAUNCH]
        |=> busy && rom_req && rom_addr == {$past(st_r.beg), 8'h00};
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not start at sector base");

    property p_no_launch;
        @(posedge clk) disable iff (!rstn)
        !busy ##1 busy |-> $past(commit && pwrite && sel_ctrl && pwdata[crcs_pkg::CTRL_LAUNCH]);
    endproperty
    a_no_launch: assert property (p_no_launch) else $error("batch started without launch");

    property p_clip;
        @(posedge clk) disable iff (!rstn)
        busy |-> st_r.last_sec == ((8'(st_r.beg) + 8'(st_r.cnt) > 8'h7f) ? 7'h7f : 7'(st_r.beg + st_r.cnt));
    endproperty
    a_clip: assert property (p_clip) else $error("last sector not start plus offset or clipped");

    property p_ascend;
        @(posedge clk) disable iff (!rstn)
        busy && rom_rvalid && !last_byte |=> rom_req && rom_addr == $past(rom_addr) + 15'h0001;
    endproperty
    a_ascend: assert property (p_ascend) else $error("rom address did not step by one");

    property p_din_reads_zero;
        @(posedge clk) disable iff (!rstn)
        psel && penable && !pwrite && sel_din && !pready ##1 pready |-> prdata == 32'h0000_0000;
    endproperty
    a_din_reads_zero: assert property (p_din_reads_zero) else $error("input port read nonzero");

    property p_dr_read;
        @(posedge clk) disable iff (!rstn)
        pready && psel && !pwrite && sel_dr
        |-> prdata[7:0] == (st_r.pnt ? st_r.crc[15:8] : st_r.crc[7:0]) && prdata[31:8] == 24'h0;
    endproperty
    a_dr_read: assert property (p_dr_read) else $error("result port gave wrong half");

    property p_din_update;
        @(posedge clk) disable iff (!rstn)
        commit && pwrite && sel_din && st_r.crc == 16'hffff && pwdata[7:0] == 8'h31 |=> st_r.crc == 16'hc782;
    endproperty
    a_din_update: assert property (p_din_update) else $error("byte update wrong");

    property p_busy_stalls;
        @(posedge clk) disable iff (!rstn)
        busy |-> !pready;
    endproperty
    a_busy_stalls: assert property (p_busy_stalls) else $error("bus answered during batch");

    property p_dr_write;
        @(posedge clk) disable iff (!rstn)
        commit && pwrite && sel_dr
        |=> (st_r.pnt ? st_r.crc[15:8] : st_r.crc[7:0]) == $past(pwdata[7:0]);
    endproperty
    a_dr_write: assert property (p_dr_write) else $error("result port write missed pointed half");

    property p_rom_req_pulse;
        @(posedge clk) disable iff (!rstn)
        rom_req |=> !rom_req;
    endproperty
    a_rom_req_pulse: assert property (p_rom_req_pulse) else $error("rom request held two cycles");

    property p_irq_level;
        @(posedge clk) disable iff (!rstn)
        irq == |(st_r.irq_sts & st_r.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt does not follow status and mask");

    property p_bad_addr;
        @(posedge clk) disable iff (!rstn)
        commit && !mapped |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");

endmodule

// ---- hw/crcs_update.sv ----
/*
 * crcs_update: one-byte parallel CRC-16 update, purely combinational.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module crcs_update #(
    parameter logic [15:0] POLY = crcs_pkg::CRC_POLY
) (
    // operands
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data_in,
    // result
    output logic      [15:0] crc_out
);

    logic [15:0] c;
    logic        fb;

    // msb first, no reflection, no final xor; unrolled into one cycle
    always_comb begin
        c  = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ data_in[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ POLY;
            end
        end
        crc_out = c;
    end

endmodule

// ---- tb/crcs_tb_top.sv ----
/*
 * crcs_tb_top: self-checking bench for crcs_top over APB with a ROM responder.
 * Assumes the crcs_pkg register indices and the pready/rom_rvalid handshakes.
 */
`timescale 1ns/1ps
module crcs_tb_top;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rom_req;
    logic [14:0] rom_addr;
    logic [7:0]  rom_rdata  = 8'h00;
    logic        rom_rvalid = 1'b0;
    logic        irq;
    logic        pend       = 1'b0;
    logic [14:0] exp_base;
    logic [14:0] req_addr;
    int          nbytes     = 0;
    int          n0;
    int          err_total;
    int          compares;
    logic [31:0] rd;
    logic        er;
    logic [15:0] ref_crc;

    typedef struct {
        logic [15:0] idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        err;
    } crcs_row_t;

    crcs_row_t rows[5] = '{
        '{crcs_pkg::IDX_BEG,  32'h0000_01ff, 32'h0000_007f, 1'b0},
        '{crcs_pkg::IDX_CNT,  32'h0000_00ff, 32'h0000_007f, 1'b0},
        '{crcs_pkg::IDX_DIN,  32'h0000_00a5, 32'h0000_0000, 1'b0},
        '{crcs_pkg::IDX_CTRL, 32'h0000_0005, 32'h0000_0015, 1'b0},
        '{16'h4030,           32'h0000_00ff, 32'h0000_0000, 1'b1}
    };

    crcs_top i_dut (
        .clk        (clk),
        .rstn       (rstn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .rom_req    (rom_req),
        .rom_addr   (rom_addr),
        .rom_rdata  (rom_rdata),
        .rom_rvalid (rom_rvalid),
        .irq        (irq)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [7:0] rom_byte(logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5c;
    endfunction

    // bitwise msb-first model, deliberately unlike a parallel table
    function automatic logic [15:0] crc_ref(logic [15:0] c, logic [7:0] d);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ 16'h1021;
            end
        end
        return c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle limit here; only the watchdog ends a stalled access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // rom answers two cycles after each request; data toggles when not valid
    always @(posedge clk) begin
        rom_rvalid <= 1'b0;
        rom_rdata  <= ~rom_rdata;
        if (pend) begin
            rom_rvalid <= 1'b1;
            rom_rdata  <= rom_byte(req_addr);
            pend       <= 1'b0;
        end
        if (rom_req === 1'b1) begin
            chk({17'h0, rom_addr}, {17'h0, exp_base + 15'(nbytes - n0)});
            req_addr <= rom_addr;
            nbytes   <= nbytes + 1;
            pend     <= 1'b1;
        end
    end

    task automatic batch(input logic [6:0] beg, input logic [6:0] cnt, input int nsec);
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_000c);
        apb(1'b1, crcs_pkg::IDX_BEG, {25'h0, beg});
        apb(1'b1, crcs_pkg::IDX_CNT, {25'h0, cnt});
        exp_base = {beg, 8'h00};
        n0       = nbytes;
        ref_crc = 16'hffff;
        for (int a = 0; a < nsec * 256; a++) begin
            ref_crc = crc_ref(ref_crc, rom_byte({beg, 8'h00} + a[14:0]));
        end
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_0006);
        apb(1'b0, crcs_pkg::IDX_CTRL, 32'h0);
        chk(rd, 32'h0000_0014);
        chk(nbytes - n0, nsec * 256);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, {24'h0, ref_crc[7:0]});
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_0001);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, {24'h0, ref_crc[15:8]});
        apb(1'b1, crcs_pkg::IDX_IRQ_STS, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        exp_base = '0;
        n0 = 0;
        err_total = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, crcs_pkg::IDX_CTRL, 32'h0);
        chk(rd, 32'h0000_0010);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, rows[i].wd);
            apb(1'b0, rows[i].idx, 32'h0);
            chk(rd, rows[i].rd);
            chk({31'h0, er}, {31'h0, rows[i].err});
        end
        // single byte: 0xffff then 0x31; launch stays zero throughout
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_000c);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, 32'h0000_00ff);
        apb(1'b1, crcs_pkg::IDX_DIN, 32'h0000_0031);
        ref_crc = crc_ref(16'hffff, 8'h31);
        chk({16'h0, ref_crc}, 32'h0000_c782);
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_0000);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, 32'h0000_0082);
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_0001);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, 32'h0000_00c7);
        chk({31'h0, irq}, 32'h0);
        // result written through the pointer, then cleared by init
        apb(1'b1, crcs_pkg::IDX_DR, 32'h0000_0012);
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_0000);
        apb(1'b1, crcs_pkg::IDX_DR, 32'h0000_0034);
        apb(1'b1, crcs_pkg::IDX_DIN, 32'h0000_0000);
        ref_crc = crc_ref(16'h1234, 8'h00);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, {24'h0, ref_crc[7:0]});
        apb(1'b1, crcs_pkg::IDX_CTRL, 32'h0000_0008);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, crcs_pkg::IDX_IRQ_STS, 32'h0000_0003);
        apb(1'b1, crcs_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        batch(7'h03, 7'h00, 1);
        batch(7'h7e, 7'h05, 2);
        // reset after the second batch clears result, fields and flags
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, crcs_pkg::IDX_BEG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, crcs_pkg::IDX_CTRL, 32'h0);
        chk(rd, 32'h0000_0010);
        apb(1'b0, crcs_pkg::IDX_DR, 32'h0);
        chk(rd, 32'h0);
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule
